// ### rtl/rcs_regs.svh
// Constants of the run-control load/step sequencer.
// Assumes a 125 MHz pclk; included by bare name.
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH
`define RCS_CLK_PERIOD_NS 8
`define RCS_STROBE_SPACING_US 10
`define RCS_STROBE_SPACING_CYC ((`RCS_STROBE_SPACING_US * 1000) / `RCS_CLK_PERIOD_NS)
`define RCS_WORD_W 12
`define RCS_CHAR_W 3
`define RCS_CHAR_LSB 9
`define RCS_ACC_RST 12'h000
`define RCS_PC_RST 12'h000
`define RCS_OP_BIT10 9
// Synchroniser reset: every input at its idle level
`define RCS_SYNC_RST 14'h3F87
`endif

// ### rtl/rcs_pkg.sv
// Types of the run-control load/step sequencer.
// Assumes nothing beyond the constant header.
package rcs_pkg;
  typedef enum logic [3:0] {
    RCS_IDLE = 4'h0,
    RCS_F1   = 4'h1,
    RCS_F2   = 4'h2,
    RCS_F3   = 4'h3,
    RCS_F4   = 4'h4,
    RCS_F5   = 4'h5,
    RCS_E1   = 4'h6,
    RCS_E2   = 4'h7,
    RCS_E3   = 4'h8
  } rcs_state_t;

  // Active-low character lines as they arrive from the I/O bus
  typedef struct packed {
    logic strobe_n;
    logic halt_n;
    logic bit5_n;
    logic delete_n;
    logic [2:0] data_n;
  } rcs_char_in_t;

  // Memory side request of one cycle
  typedef struct packed {
    logic        dir_read;
    logic        start;
    logic [11:0] addr;
    logic [11:0] wdata;
    logic        write;
  } rcs_mem_req_t;
endpackage : rcs_pkg

// ### rtl/rcs_sequencer.sv
// Run-control sequencer: load mode, single step, panel truncated fetch.
// Assumes panel and I/O pins asynchronous to pclk; memory answers on pclk.
//
// Local design decisions: the APB slave port and the placing of the registers.
`include "rcs_regs.svh"

// How it works
// - Halt character in load mode clears run
// - Load switch forces op bit 10
// - Accumulator shifts in fetch states 1-3
// - Shifts gated by clock, load, not blank
// - Fetch 1 latches PC into address register
// - Fetch 1 clears strobe-seen flag
// - Fetch 2 sets read direction, starts memory
// - PC advances every fourth accepted character
// - Fetch 3 counts non-blank characters
// - Fetch 3 clears memory data register
// - Fetch 4 loads character into accumulator top
// - Active-low inputs inverted inside
// - Exec 1 moves accumulator to data register
// - Store ends exec 3, waits for strobe
// - Single step on halt select or fault
// - Start press sets run flag
// - Single step: final exec clears run
// - Run selected: final exec continues fetching
// - Other panel functions only while halted
// - Panel fetch stops after fetch 4
// - Truncated fetch keeps word, advances PC
// - Blank when bits 1,2,3,5 zero or delete
// - Strobe edge sets strobe-seen under load
// - Active-low load-mode output while loading
module rcs_sequencer (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Character input from the I/O bus
  input  wire rcs_pkg::rcs_char_in_t char_in,
  output logic                      load_mode_out_n,
  // Operator panel and remote panel
  input  wire logic                 panel_go,
  input  wire logic                 remote_go,
  input  wire logic                 panel_halt_sel,
  input  wire logic                 remote_halt_sel,
  input  wire logic                 supply_fault_n,
  input  wire logic                 load_switch_n,
  input  wire logic                 panel_fetch_n,
  // Memory
  output rcs_pkg::rcs_mem_req_t     mem_req,
  input  wire logic [11:0]          mem_rdata,
  input  wire logic                 mem_rvalid,
  // Status
  output logic                      run_flag,
  output logic                      single_step_mode,
  output logic [3:0]                timing_state
);

  //------------------------------------------------------------
  // Input synchronisers
  //------------------------------------------------------------
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  assign raw_in = {char_in, panel_go, remote_go, panel_halt_sel, remote_halt_sel,
                   supply_fault_n, load_switch_n, panel_fetch_n};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle pin levels, so no false start edge after reset
      sync1 <= `RCS_SYNC_RST;
      sync2 <= `RCS_SYNC_RST;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  // Active-low lines inverted to active-high
  rcs_pkg::rcs_char_in_t ci_n;
  logic       strobe_lvl;
  logic       halt_char_line;
  logic [2:0] char_bits;
  logic       bit5;
  logic       delete_bit;
  logic       go_s;
  logic       rgo_s;
  logic       halt_s;
  logic       rhalt_s;
  logic       fault;
  logic       load_sw;
  logic       fetch_sw;
  assign ci_n           = rcs_pkg::rcs_char_in_t'(sync2[13:7]);
  assign strobe_lvl     = ~ci_n.strobe_n;
  assign halt_char_line = ~ci_n.halt_n;
  assign char_bits      = ~ci_n.data_n;
  assign bit5           = ~ci_n.bit5_n;
  assign delete_bit     = ~ci_n.delete_n;
  assign go_s           = sync2[6];
  assign rgo_s          = sync2[5];
  assign halt_s         = sync2[4];
  assign rhalt_s        = sync2[3];
  assign fault          = ~sync2[2];
  assign load_sw        = ~sync2[1];
  assign fetch_sw       = ~sync2[0];

  //------------------------------------------------------------
  // Decoding
  //------------------------------------------------------------
  rcs_pkg::rcs_state_t state;
  rcs_pkg::rcs_state_t next_state;
  logic        strobe_q;
  logic        go_q;
  logic        strobe_seen_flag;
  logic [1:0]  char_count;
  logic [11:0] acc;
  logic [11:0] pc;
  logic [11:0] mar;
  logic [11:0] mdr;
  logic [11:0] op_reg;
  logic        mem_dir_flag;
  logic        mem_cycle_start_flag;

  logic fetch_state_1;
  logic fetch_state_2;
  logic fetch_state_3;
  logic fetch_state_4;
  logic exec_state_1;
  logic exec_state_3;
  assign fetch_state_1 = (state == rcs_pkg::RCS_F1);
  assign fetch_state_2 = (state == rcs_pkg::RCS_F2);
  assign fetch_state_3 = (state == rcs_pkg::RCS_F3);
  assign fetch_state_4 = (state == rcs_pkg::RCS_F4);
  assign exec_state_1  = (state == rcs_pkg::RCS_E1);
  assign exec_state_3  = (state == rcs_pkg::RCS_E3);

  logic load_active;
  logic blank_char_n;
  logic acc_shift_pulse;
  logic char_count_pulse;
  logic pc_advance;
  logic strobe_edge;
  logic go_edge;
  logic final_exec_time;
  logic fetch_or_store_req;
  logic halt_timer_n;
  logic halt_char_stop;
  logic step_stop;
  logic store_accumulator_op;
  logic        apb_wr;
  logic        wr_acc;
  logic        wr_pc;
  logic        wr_op;
  logic [31:0] rd_mux;

  assign load_active      = load_sw & run_flag;
  assign load_mode_out_n  = ~load_active;
  assign blank_char_n     = ~(((char_bits == 3'h0) & ~bit5) | delete_bit);
  assign acc_shift_pulse  = load_active & blank_char_n &
                            (fetch_state_1 | fetch_state_2 | fetch_state_3);
  assign char_count_pulse = load_sw & blank_char_n & fetch_state_3;
  assign pc_advance       = fetch_state_2 & (load_sw ? (&char_count) & blank_char_n
                                                     : 1'b1);
  assign strobe_edge      = strobe_lvl & ~strobe_q;
  assign go_edge          = (go_s | rgo_s) & ~go_q;
  // Halt selection ignored while loading
  assign single_step_mode = (halt_s | rhalt_s | fault) & ~load_sw;
  assign final_exec_time  = exec_state_3;
  // Panel fetch only accepted while halted
  assign fetch_or_store_req = fetch_sw & (halt_s | rhalt_s) & ~load_sw;
  assign halt_timer_n     = ~(fetch_or_store_req & fetch_state_4);
  assign halt_char_stop   = load_active & halt_char_line;
  assign step_stop        = single_step_mode & final_exec_time;
  assign store_accumulator_op = op_reg[`RCS_OP_BIT10];
  assign timing_state     = state;
  // Refused offsets never write
  assign apb_wr = psel & penable & pwrite & (paddr[11:4] == 8'h00);
  assign wr_acc = apb_wr & (paddr[3:2] == 2'h0);
  assign wr_op  = apb_wr & (paddr[3:2] == 2'h2);
  // Program counter locked while running
  assign wr_pc  = apb_wr & (paddr[3:2] == 2'h1) & ~run_flag;

  //------------------------------------------------------------
  // Timing states
  //------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      rcs_pkg::RCS_IDLE: begin
        if (run_flag && (!load_sw || strobe_seen_flag)) begin
          next_state = rcs_pkg::RCS_F1;
        end
      end
      rcs_pkg::RCS_F1: next_state = rcs_pkg::RCS_F2;
      rcs_pkg::RCS_F2: next_state = rcs_pkg::RCS_F3;
      rcs_pkg::RCS_F3: next_state = rcs_pkg::RCS_F4;
      rcs_pkg::RCS_F4: begin
        if (!halt_timer_n) begin
          next_state = rcs_pkg::RCS_IDLE;
        end else begin
          next_state = rcs_pkg::RCS_F5;
        end
      end
      rcs_pkg::RCS_F5: next_state = rcs_pkg::RCS_E1;
      rcs_pkg::RCS_E1: next_state = rcs_pkg::RCS_E2;
      rcs_pkg::RCS_E2: next_state = rcs_pkg::RCS_E3;
      rcs_pkg::RCS_E3: begin
        if (load_sw || step_stop) begin
          next_state = rcs_pkg::RCS_IDLE;
        end else begin
          next_state = rcs_pkg::RCS_F1;
        end
      end
      default: next_state = rcs_pkg::RCS_IDLE;
    endcase
    if (!run_flag || halt_char_stop) begin
      next_state = rcs_pkg::RCS_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rcs_pkg::RCS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  //------------------------------------------------------------
  // Run flag and edge detectors
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_flag <= 1'b0;
      strobe_q <= 1'b0;
      go_q     <= 1'b0;
    end else begin
      strobe_q <= strobe_lvl;
      go_q     <= go_s | rgo_s;
      if (halt_char_stop || step_stop || !halt_timer_n) begin
        run_flag <= 1'b0;
      end else if (go_edge) begin
        run_flag <= 1'b1;
      end
    end
  end

  //------------------------------------------------------------
  // Strobe-seen flag; set wins over clear
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_seen_flag <= 1'b0;
    end else if (load_sw && strobe_edge) begin
      strobe_seen_flag <= 1'b1;
    end else if (fetch_state_1) begin
      strobe_seen_flag <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // Data path registers
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc        <= `RCS_ACC_RST;
      pc         <= `RCS_PC_RST;
      mar        <= 12'h000;
      mdr        <= 12'h000;
      op_reg     <= 12'h000;
      char_count <= 2'h0;
    end else begin
      if (load_sw) begin
        op_reg[`RCS_OP_BIT10] <= 1'b1;
      end else if (wr_op) begin
        op_reg <= pwdata[11:0];
      end
      if (acc_shift_pulse) begin
        acc <= {1'b0, acc[11:1]};
      end else if (load_active && fetch_state_4 && blank_char_n) begin
        acc[11:`RCS_CHAR_LSB] <= char_bits;
      end else if (wr_acc) begin
        acc <= pwdata[11:0];
      end
      if (fetch_state_1) begin
        mar <= pc;
      end
      if (pc_advance) begin
        pc <= pc + 12'h001;
      end else if (wr_pc) begin
        pc <= pwdata[11:0];
      end
      if (char_count_pulse) begin
        char_count <= char_count + 2'h1;
      end
      if (fetch_state_3) begin
        mdr <= 12'h000;
      end else if (exec_state_1 && store_accumulator_op) begin
        mdr <= acc;
      end else if (mem_rvalid && mem_dir_flag) begin
        mdr <= mem_rdata;
      end
    end
  end

  //------------------------------------------------------------
  // Memory control
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_dir_flag         <= 1'b0;
      mem_cycle_start_flag <= 1'b0;
      mem_req              <= '0;
    end else begin
      if (fetch_state_2) begin
        mem_dir_flag <= 1'b1;
      end else if (exec_state_1 && store_accumulator_op) begin
        mem_dir_flag <= 1'b0;
      end
      mem_cycle_start_flag <= fetch_state_2;
      mem_req.dir_read     <= mem_dir_flag | fetch_state_2;
      mem_req.start        <= fetch_state_2;
      mem_req.addr         <= mar;
      mem_req.wdata        <= mdr;
      mem_req.write        <= exec_state_3 & store_accumulator_op;
    end
  end

  //------------------------------------------------------------
  // APB slave, zero wait states
  //------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr[11:4] != 8'h00);
  assign rd_mux  = (paddr[11:4] != 8'h00) ? 32'h0000_0000 :
                   (paddr[3:2] == 2'h0)   ? {20'h0_0000, acc} :
                   (paddr[3:2] == 2'h1)   ? {20'h0_0000, pc} :
                   (paddr[3:2] == 2'h2)   ? {20'h0_0000, op_reg} :
                   {20'h0_0000, mdr[11:8], state, load_active, single_step_mode,
                    strobe_seen_flag, run_flag};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule : rcs_sequencer

// ### verif/rcs_sequencer_asserts.sv
// Concurrent checks on the sequencer's ports.
// Assumes a bind to rcs_sequencer; one clock domain on pclk.
module rcs_sequencer_asserts (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // Load link and panel
  input wire rcs_pkg::rcs_char_in_t char_in,
  input wire logic                  load_mode_out_n,
  input wire logic                  panel_halt_sel,
  input wire logic                  load_switch_n,
  input wire logic                  panel_fetch_n,
  // Memory and status
  input wire rcs_pkg::rcs_mem_req_t mem_req,
  input wire logic                  run_flag,
  input wire logic                  single_step_mode,
  input wire logic [3:0]            timing_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_halt_stops_run: assert property (run_flag && !load_switch_n && !char_in.halt_n
    |-> ##[1:4] !run_flag)
    else $error("halt character left the run flag set");
  chk_load_out_idle: assert property (!run_flag |-> load_mode_out_n)
    else $error("load mode output active while stopped");
  chk_fetch_order: assert property (timing_state inside {rcs_pkg::RCS_F1, rcs_pkg::RCS_F2,
    rcs_pkg::RCS_F3} |=> timing_state == $past(timing_state) + 4'h1)
    else $error("fetch states out of order");
  chk_mem_start: assert property (timing_state == rcs_pkg::RCS_F2 |=> mem_req.start && mem_req.dir_read)
    else $error("no read cycle started after fetch 2");
  chk_start_pulse: assert property (mem_req.start |=> !mem_req.start)
    else $error("memory start longer than one cycle");
  chk_fetch_truncated: assert property (!panel_fetch_n && panel_halt_sel && load_switch_n
    && timing_state == rcs_pkg::RCS_F4 |=> timing_state != rcs_pkg::RCS_F5 && !run_flag)
    else $error("truncated fetch went past fetch 4");
  chk_step_stops: assert property (single_step_mode && timing_state == rcs_pkg::RCS_F1
    |-> ##[1:12] !run_flag)
    else $error("single step did not halt");
  chk_run_continues: assert property (run_flag && $past(run_flag, 2) && load_switch_n
    && !single_step_mode |-> timing_state != rcs_pkg::RCS_IDLE)
    else $error("run mode idled between instructions");
endmodule : rcs_sequencer_asserts

// ### verif/rcs_tape_model.sv
// Character source on the load link, a tape reader in behaviour.
// Assumes lclk from the bench; released lines float passive high.
module rcs_tape_model (
  // Link clock and load request
  input wire logic           lclk,
  input wire logic           load_mode_out_n,
  // Character lines
  output rcs_pkg::rcs_char_in_t char_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD_CYC = 47;
  localparam int GAP_CYC  = 157;

  int n_timeout = 0;

  initial char_in = '1;

  task automatic send_char(input logic [2:0] v, input logic b5, input logic del);
    int n;
    n = 0;
    while (load_mode_out_n !== 1'b0 && n < 1000) begin
      @(posedge lclk);
      n++;
    end
    if (n >= 1000) n_timeout++;
    @(posedge lclk);
    char_in.data_n   <= ~v;
    char_in.bit5_n   <= ~b5;
    char_in.delete_n <= ~del;
    @(posedge lclk);
    char_in.strobe_n <= 1'b0;
    repeat (8) @(posedge lclk);
    char_in.strobe_n <= 1'b1;
    repeat (HOLD_CYC - 8) @(posedge lclk);
    char_in <= '1;
    repeat (GAP_CYC - HOLD_CYC) @(posedge lclk);
  endtask : send_char

  task automatic send_halt();
    @(posedge lclk);
    char_in.halt_n <= 1'b0;
    repeat (8) @(posedge lclk);
    char_in.halt_n <= 1'b1;
  endtask : send_halt
endmodule : rcs_tape_model

// ### verif/run_control_load_step_sequencer_test.sv
// Bench for the run-control sequencer: APB, panel, memory and tape.
// Assumes the design and tape model compiled before this file.
module run_control_load_step_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                  pclk = 1'b0, lclk = 1'b0, presetn = 1'b0;
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]           paddr = 12'h000, rd_word = 12'h000, mem_rdata = 12'h000, rd_addr, wr_addr, wr_data;
  logic [31:0]           pwdata = 32'h0, prdata, q;
  logic                  pready, pslverr, bus_err, load_mode_out_n, run_flag, single_step_mode, mem_rvalid = 1'b0;
  logic                  panel_go = 1'b0, remote_go = 1'b0, panel_halt_sel = 1'b1, remote_halt_sel = 1'b0;
  logic                  supply_fault_n = 1'b1, load_switch_n = 1'b1, panel_fetch_n = 1'b1;
  logic [3:0]            timing_state;
  rcs_pkg::rcs_char_in_t char_in;
  rcs_pkg::rcs_mem_req_t mem_req;
  int                    n_mismatch = 0, check_count = 0;

  always #4 pclk = ~pclk;
  always #32 lclk = ~lclk;

  rcs_sequencer rcs_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .char_in(char_in),
    .load_mode_out_n(load_mode_out_n), .panel_go(panel_go), .remote_go(remote_go), .panel_halt_sel(panel_halt_sel),
    .remote_halt_sel(remote_halt_sel), .supply_fault_n(supply_fault_n), .load_switch_n(load_switch_n),
    .panel_fetch_n(panel_fetch_n), .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .run_flag(run_flag), .single_step_mode(single_step_mode), .timing_state(timing_state));
  rcs_tape_model rcs_tape_model_i (.lclk(lclk), .load_mode_out_n(load_mode_out_n), .char_in(char_in));

  // ----------------------------------------
  // Memory responder
  // ----------------------------------------
  always @(posedge pclk) begin
    mem_rvalid <= mem_req.start && mem_req.dir_read;
    mem_rdata  <= (mem_req.start && mem_req.dir_read) ? rd_word : ~rd_word;
    if (mem_req.start) rd_addr <= mem_req.addr;
    if (mem_req.write) wr_addr <= mem_req.addr;
    if (mem_req.write) wr_data <= mem_req.wdata;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) n_mismatch++;
    if (n >= 64) tally_and_finish();
    q       = prdata;
    bus_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic press();
    panel_go <= 1'b1;
    repeat (4) @(posedge pclk);
    panel_go <= 1'b0;
  endtask : press

  task automatic wait_stop();
    int n;
    n = 0;
    while ((run_flag !== 1'b0 || timing_state !== 4'h0) && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) n_mismatch++;
    if (n >= 3000) tally_and_finish();
  endtask : wait_stop

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(q, (i == 3) ? 32'h4 : 32'h0);
    end
    apb(1'b0, 12'h010, 32'h0);
    chk({q[30:0], bus_err}, 32'h1);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      panel_halt_sel  <= i[0];
      remote_halt_sel <= i[1];
      supply_fault_n  <= !i[2];
      load_switch_n   <= !i[3];
      repeat (4) @(posedge pclk);
      chk(32'(single_step_mode), 32'((i[2:0] != 3'h0) && !i[3]));
    end
    panel_halt_sel  <= 1'b1;
    remote_halt_sel <= 1'b0;
    supply_fault_n  <= 1'b1;
    load_switch_n   <= 1'b1;
    $display("step select test done");
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, 12'h004, 32'h020);
    panel_fetch_n <= 1'b0;
    rd_word       <= 12'hA5C;
    press();
    wait_stop();
    panel_fetch_n <= 1'b1;
    chk(32'(rd_addr), 32'h020);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h021);
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'(q[11:8]), 32'hA);
    $display("fetch test done");
    apb(1'b1, 12'h004, 32'h030);
    rd_word <= 12'h000;
    press();
    wait_stop();
    chk(32'(rd_addr), 32'h030);
    panel_halt_sel <= 1'b0;
    remote_go      <= 1'b1;
    repeat (4) @(posedge pclk);
    remote_go <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(32'(run_flag), 32'h1);
    panel_fetch_n <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(32'(run_flag), 32'h1);
    panel_fetch_n  <= 1'b1;
    supply_fault_n <= 1'b0;
    wait_stop();
    chk(32'(single_step_mode), 32'h1);
    supply_fault_n <= 1'b1;
    panel_halt_sel <= 1'b1;
    $display("step and run test done");
    load_switch_n <= 1'b0;
    apb(1'b1, 12'h004, 32'h040);
    apb(1'b0, 12'h008, 32'h0);
    chk(32'(q[9]), 32'h1);
    press();
    repeat (8) @(posedge pclk);
    chk(32'(load_mode_out_n), 32'h0);
    for (int c = 1; c < 5; c++) rcs_tape_model_i.send_char(3'(c), 1'b1, 1'b0);
    chk({8'h0, wr_addr, wr_data}, {8'h0, 12'h040, 12'h8D1});
    apb(1'b0, 12'h00C, 32'h0);
    chk({28'h0, q[11:8]} | {q[7:0], 24'h0}, 32'h0900_0008);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h041);
    rcs_tape_model_i.send_char(3'h0, 1'b0, 1'b0);
    rcs_tape_model_i.send_char(3'h7, 1'b1, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h8D1);
    rcs_tape_model_i.send_char(3'h5, 1'b1, 1'b0);
    chk({8'h0, wr_addr, wr_data}, {8'h0, 12'h041, 12'hB1A});
    rcs_tape_model_i.send_halt();
    wait_stop();
    chk(32'(load_mode_out_n), 32'h1);
    chk(32'(rcs_tape_model_i.n_timeout), 32'h0);
    load_switch_n <= 1'b1;
    $display("load test done");
    tally_and_finish();
  end
endmodule : run_control_load_step_sequencer_test

bind rcs_sequencer rcs_sequencer_asserts rcs_sequencer_asserts_i (.pclk(pclk), .presetn(presetn), .char_in(char_in),
  .load_mode_out_n(load_mode_out_n), .panel_halt_sel(panel_halt_sel), .load_switch_n(load_switch_n),
  .panel_fetch_n(panel_fetch_n), .mem_req(mem_req), .run_flag(run_flag), .single_step_mode(single_step_mode),
  .timing_state(timing_state));
